/* File: hdl/ucc_cfg.svh */
`ifndef UCC_CFG_SVH
`define UCC_CFG_SVH

// register offsets on the local port
`define UCC_A_STATUS  3'h0
`define UCC_A_CTRL1   3'h1
`define UCC_A_CTRL2   3'h2
`define UCC_A_DATA    3'h3
`define UCC_A_DIVL    3'h4
`define UCC_A_DIVH    3'h5

// reset values
`define UCC_STATUS_RST 8'h0b
`define UCC_CTRL1_RST  8'h00
`define UCC_CTRL2_RST  8'h00
`define UCC_DIV_RST    8'h00

// control_one fields
`define UCC_C1_EN    7
`define UCC_C1_BNO   6
`define UCC_C1_PREN  5
`define UCC_C1_PT_HI 4
`define UCC_C1_PT_LO 3
`define UCC_C1_BRK   2
`define UCC_C1_TX8   0

// control_two fields
`define UCC_C2_TXEN  7
`define UCC_C2_RXEN  6
`define UCC_C2_STOP  5
`define UCC_C2_ADDR  4
`define UCC_C2_WAKE  3
`define UCC_C2_RIE   2
`define UCC_C2_TIIE  1
`define UCC_C2_TEIE  0

// parity type codes
`define UCC_PAR_EVEN  2'h0
`define UCC_PAR_ODD   2'h1
`define UCC_PAR_MARK  2'h2
`define UCC_PAR_SPACE 2'h3

// timing in bit times and clocks
`define UCC_DIV_MIN    16'h0010
`define UCC_BREAK_BITS 4'hd
`define UCC_BASE_BITS  4'ha
`define UCC_RX_LAST    4'h8

`endif

/* File: hdl/ucc_pkg.sv */
package ucc_pkg;

	typedef enum logic [2:0] {
		UCC_TX_IDLE  = 3'h1,
		UCC_TX_SHIFT = 3'h2,
		UCC_TX_BREAK = 3'h4
	} ucc_tx_state_t;

	typedef enum logic [2:0] {
		UCC_RX_IDLE  = 3'h1,
		UCC_RX_START = 3'h2,
		UCC_RX_DATA  = 3'h4
	} ucc_rx_state_t;

	typedef struct packed {
		logic perr;
		logic nf;
		logic ferr;
		logic oerr;
		logic ridle;
		logic rxif;
		logic tidle;
		logic txif;
	} ucc_status_t;

endpackage

/* File: hdl/ucc_top.sv */
`timescale 1ns/1ps
`include "ucc_cfg.svh"

// Summary of operation
// [R1] unit_enable low disables the unit and floats both serial pins
// [R2] disabling drops buffered characters and resets the baud counters
// [R3] disabling clears enables, break, receive and error flags; sets idles
// [R4] clearing unit_enable aborts traffic; re-enable keeps configuration
// [R5] word_length_select picks 8 or 9 data bits
// [R6] ninth bit received into rx_ninth_bit, sent from tx_ninth_bit
// [R7] with parity on the last word bit is parity, not stored as data
// [R8] parity generated and checked only while parity_enable is set
// [R9] parity_type: even, odd, mark, space
// [R10] break waits for buffered data, then low at least 13 bits
// [R11] transmitter_enable low aborts, resets transmitter, floats output
// [R12] output driven only with transmitter_enable and unit_enable high
// [R13] receiver_enable low aborts reception and resets receive buffer; code keeps rx_data and rxif
// [R14] input taken only with receiver_enable and unit_enable high
// [R15] stop_bit_count selects one or two stop bits
// [R16] address detect: word with top bit set is an address, interrupts
// [R17] address detect: word with top bit clear is dropped silently
// [R18] falling input edge wakes only while source clock is off
// [R19] receive_irq_enable gates overrun and receive-available requests
// [R20] tx_idle_irq_enable gates the transmit idle request
// [R21] tx_empty_irq_enable gates the transmit empty request
// [R22] status read then data access clears the error flags
// [R23] transmitter_enable set makes tx_empty_flag set
// [R24] one interrupt output ORs all enabled sources
module ucc_top import ucc_pkg::*; (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            serial_out_pin,
	output logic            serial_out_oe_n,
	input  wire logic       serial_in_pin,
	output logic            serial_in_owned,
	input  wire logic       src_clk_off,
	output logic            wake_req,
	output logic            irq
);

	// clamp the divider so a zero setting still yields a bit time
	function automatic logic [15:0] div_eff(input logic [15:0] d);
		div_eff = (d < `UCC_DIV_MIN) ? `UCC_DIV_MIN : d;
	endfunction

	function automatic logic par_bit(input logic [1:0] t,
		input logic [8:0] v);
		unique case (t)
		`UCC_PAR_EVEN:  par_bit = ^v;
		`UCC_PAR_ODD:   par_bit = ~^v;
		`UCC_PAR_MARK:  par_bit = 1'b1;
		`UCC_PAR_SPACE: par_bit = 1'b0;
		endcase
	endfunction

	logic [7:0]    c1;
	logic [7:0]    c2;
	logic [7:0]    div_l;
	logic [7:0]    div_h;
	logic [15:0]   dv;
	logic [7:0]    tx_buf;
	logic [7:0]    rx_data;
	logic          rx_ninth;
	ucc_status_t   st;
	ucc_status_t   snap;
	logic          en;
	logic          tx_on;
	logic          rx_on;
	logic          brk;
	logic          bno;
	logic          pren;
	logic [1:0]    ptype;
	logic          st_rd;
	logic          dat_rd;
	logic          dat_wr;
	ucc_tx_state_t tx_st;
	logic [15:0]   tx_cnt;
	logic [11:0]   tx_sh;
	logic [3:0]    tx_left;
	logic [3:0]    brk_bits;
	logic          tx_tick;
	logic          tx_load;
	logic [7:0]    tx_d;
	logic          tx_n9;
	logic          s1;
	logic          s2;
	logic          s3;
	logic          rx_lvl;
	logic          rx_prev;
	logic          rx_fall;
	ucc_rx_state_t rx_st;
	logic [15:0]   rx_cnt;
	logic [3:0]    rx_n;
	logic [8:0]    rx_sh;
	logic          noisy;
	logic          rx_tick;
	logic          rx_done;
	logic          abit;
	logic          keep;
	logic          rx_full;
	logic          rx_store;

	// decoded controls and strobes
	assign en      = c1[`UCC_C1_EN];
	assign bno     = c1[`UCC_C1_BNO];
	assign pren    = c1[`UCC_C1_PREN];
	assign ptype   = c1[`UCC_C1_PT_HI:`UCC_C1_PT_LO];
	assign brk     = c1[`UCC_C1_BRK];
	assign tx_on   = en & c2[`UCC_C2_TXEN];               // [R12]
	assign rx_on   = en & c2[`UCC_C2_RXEN];               // [R14]
	assign st_rd   = rd & (addr == `UCC_A_STATUS);
	assign dat_rd  = rd & (addr == `UCC_A_DATA);
	assign dat_wr  = wr & (addr == `UCC_A_DATA);
	assign dv      = div_eff({div_h, div_l});

	// pin ownership
	assign serial_out_oe_n = ~tx_on;                      // [R1] [R11]
	assign serial_in_owned = rx_on;                       // [R1] [R13]

	// control registers; enables and break drop with the unit
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			c1 <= `UCC_CTRL1_RST;
			c2 <= `UCC_CTRL2_RST;
		end else begin
			if (wr && addr == `UCC_A_CTRL1) begin
				c1    <= wdata;
				c1[1] <= 1'b0;
				c1[`UCC_C1_BRK] <= wdata[`UCC_C1_BRK] & wdata[`UCC_C1_EN];
			end else if (!en) begin
				c1[`UCC_C1_BRK] <= 1'b0;                      // [R3]
			end
			if (wr && addr == `UCC_A_CTRL2) begin
				c2 <= {wdata[7:6] & {2{en}}, wdata[5:0]};
			end else if (!en) begin
				c2[`UCC_C2_TXEN] <= 1'b0;                     // [R3]
				c2[`UCC_C2_RXEN] <= 1'b0;                     // [R3]
			end
		end
	end

	// divider and transmit holding registers keep across disable
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			div_l  <= `UCC_DIV_RST;
			div_h  <= `UCC_DIV_RST;
			tx_buf <= 8'h00;
		end else begin
			if (wr && addr == `UCC_A_DIVL)
				div_l <= wdata;
			if (wr && addr == `UCC_A_DIVH)
				div_h <= wdata;
			if (dat_wr)
				tx_buf <= wdata;
		end
	end

	// status snapshot arms the clear-on-data-access sequence
	always_ff @(posedge clk_sys) begin
		if (reset || !en) begin
			snap <= '0;
		end else if (st_rd) begin
			snap <= st;
		end else if (dat_rd || dat_wr) begin
			snap <= '0;
		end
	end

	// status flags; later assignments are sets so they win
	always_ff @(posedge clk_sys) begin
		if (reset || !en) begin
			st <= `UCC_STATUS_RST;                          // [R2] [R3] [R4]
		end else begin
			if (dat_rd || dat_wr) begin
				st.perr <= st.perr & ~snap.perr;              // [R22]
				st.nf   <= st.nf & ~snap.nf;                  // [R22]
				st.ferr <= st.ferr & ~snap.ferr;              // [R22]
				st.oerr <= st.oerr & ~snap.oerr;              // [R22]
			end
			if (dat_rd && snap.rxif)
				st.rxif <= 1'b0;
			if (dat_wr) begin
				st.txif  <= 1'b0;
				st.tidle <= 1'b0;
			end
			if (tx_load || (tx_st == UCC_TX_IDLE && brk))
				st.tidle <= 1'b0;
			st.ridle <= (rx_st == UCC_RX_IDLE);
			if (tx_load)
				st.txif <= 1'b1;
			if (st.txif && !dat_wr && !brk && tx_st == UCC_TX_IDLE)
				st.tidle <= 1'b1;
			if (!tx_on) begin
				st.txif  <= 1'b1;                             // [R11] [R23]
				st.tidle <= 1'b1;                             // [R11]
			end
			if (rx_done && keep && rx_full)
				st.oerr <= 1'b1;
			if (rx_store) begin
				st.rxif <= 1'b1;                              // [R16]
				st.ferr <= ~rx_lvl;
				st.nf   <= noisy | (s2 != s3);
				st.perr <= pren & (par_bit(ptype,             // [R8]
					bno ? {1'b0, rx_sh[7:0]} : {2'b00, rx_sh[6:0]}) != abit);
			end
		end
	end

	// transmit word: parity replaces the last data bit when enabled
	always_comb begin
		tx_d  = tx_buf;
		tx_n9 = c1[`UCC_C1_TX8];                            // [R6]
		if (pren && !bno)
			tx_d[7] = par_bit(ptype, {2'b00, tx_buf[6:0]});   // [R7] [R9]
		if (pren && bno)
			tx_n9 = par_bit(ptype, {1'b0, tx_buf});           // [R7] [R9]
	end

	assign tx_tick = (tx_cnt == dv - 16'h0001);
	assign tx_load = tx_on && tx_st == UCC_TX_IDLE && !st.txif;

	// transmitter; reset whole while disabled, counter included
	always_ff @(posedge clk_sys) begin
		if (reset || !tx_on) begin
			tx_st    <= UCC_TX_IDLE;                          // [R2] [R11]
			tx_cnt   <= 16'h0000;
			tx_sh    <= 12'hfff;
			tx_left  <= 4'h0;
			brk_bits <= 4'h0;
		end else begin
			unique case (tx_st)
			UCC_TX_IDLE: begin
				tx_cnt <= 16'h0000;
				if (tx_load) begin
					tx_sh <= bno ? {2'b11, tx_n9, tx_d, 1'b0}    // [R5] [R6]
						: {3'b111, tx_d, 1'b0};                   // [R5]
					tx_left <= `UCC_BASE_BITS + {3'b000, bno}
						+ {3'b000, c2[`UCC_C2_STOP]};             // [R15]
					tx_st <= UCC_TX_SHIFT;
				end else if (brk) begin
					brk_bits <= 4'h0;
					tx_st    <= UCC_TX_BREAK;                     // [R10]
				end
			end
			UCC_TX_SHIFT: begin
				if (tx_tick) begin
					tx_cnt  <= 16'h0000;
					tx_sh   <= {1'b1, tx_sh[11:1]};
					tx_left <= tx_left - 4'h1;
					if (tx_left == 4'h1)
						tx_st <= UCC_TX_IDLE;
				end else begin
					tx_cnt <= tx_cnt + 16'h0001;
				end
			end
			UCC_TX_BREAK: begin
				if (tx_tick) begin
					tx_cnt <= 16'h0000;
					if (brk_bits != `UCC_BREAK_BITS)
						brk_bits <= brk_bits + 4'h1;              // [R10]
				end else begin
					tx_cnt <= tx_cnt + 16'h0001;
				end
				if (brk_bits == `UCC_BREAK_BITS && !brk)
					tx_st <= UCC_TX_IDLE;                         // [R10]
			end
			endcase
		end
	end

	// output line from a flop; idle is high, break is low
	// forced high while the transmitter is off so no stale bit lingers
	always_ff @(posedge clk_sys) begin
		if (reset || !tx_on)
			serial_out_pin <= 1'b1;                       // [R11]
		else
			serial_out_pin <= (tx_st == UCC_TX_BREAK) ? 1'b0
				: (tx_st == UCC_TX_SHIFT) ? tx_sh[0] : 1'b1;      // [R10]
	end

	// input synchroniser; a level counts once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s1      <= 1'b1;
			s2      <= 1'b1;
			s3      <= 1'b1;
			rx_lvl  <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			s1      <= serial_in_pin;
			s2      <= s1;
			s3      <= s2;
			rx_prev <= rx_lvl;
			if (s2 == s3)
				rx_lvl <= s3;
		end
	end

	assign rx_fall = rx_prev & ~rx_lvl;
	assign rx_tick = (rx_cnt == dv - 16'h0001);
	assign rx_done = (rx_st == UCC_RX_DATA) && rx_tick
		&& (rx_n == `UCC_RX_LAST + {3'b000, bno});          // [R5]
	assign abit    = bno ? rx_sh[8] : rx_sh[7];           // [R16]
	assign keep    = !(c2[`UCC_C2_ADDR] && !abit);        // [R17]
	assign rx_full = st.rxif && !(dat_rd && snap.rxif);
	assign rx_store = rx_done && keep && !rx_full;

	// receiver; samples mid-bit, aborts whenever it loses the pin
	always_ff @(posedge clk_sys) begin
		if (reset || !rx_on) begin
			rx_st  <= UCC_RX_IDLE;                          // [R2] [R13]
			rx_cnt <= 16'h0000;
			rx_n   <= 4'h0;
			rx_sh  <= 9'h000;
			noisy  <= 1'b0;
		end else begin
			unique case (rx_st)
			UCC_RX_IDLE: begin
				rx_cnt <= 16'h0000;
				noisy  <= 1'b0;
				if (rx_fall)
					rx_st <= UCC_RX_START;
			end
			UCC_RX_START: begin
				if (rx_cnt == {1'b0, dv[15:1]}) begin
					rx_cnt <= 16'h0000;
					rx_n   <= 4'h0;
					rx_st  <= rx_lvl ? UCC_RX_IDLE : UCC_RX_DATA;
				end else begin
					rx_cnt <= rx_cnt + 16'h0001;
				end
			end
			UCC_RX_DATA: begin
				if (rx_tick) begin
					rx_cnt <= 16'h0000;
					rx_n   <= rx_n + 4'h1;
					noisy  <= noisy | (s2 != s3);
					if (rx_n < `UCC_RX_LAST + 4'h1)
						rx_sh[rx_n] <= rx_lvl;
					if (rx_done)
						rx_st <= UCC_RX_IDLE;
				end else begin
					rx_cnt <= rx_cnt + 16'h0001;
				end
			end
			endcase
		end
	end

	// receive data; parity bit never lands in data or ninth bit
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_data  <= 8'h00;
			rx_ninth <= 1'b0;
		end else if (rx_store) begin
			rx_data  <= {rx_sh[7] & (bno | ~pren), rx_sh[6:0]}; // [R7]
			rx_ninth <= rx_sh[8] & bno & ~pren;                 // [R6] [R7]
		end
	end

	// wake request only while the source clock is stopped
	always_ff @(posedge clk_sys) begin
		if (reset)
			wake_req <= 1'b0;
		else
			wake_req <= en & c2[`UCC_C2_WAKE] & src_clk_off & rx_fall; // [R18]
	end

	// single request from all enabled sources
	always_ff @(posedge clk_sys) begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= en & ((c2[`UCC_C2_RIE]                     // [R24]
				& (st.rxif | st.oerr | wake_req))                // [R19] [R18]
				| (c2[`UCC_C2_TIIE] & st.tidle)                  // [R20]
				| (c2[`UCC_C2_TEIE] & st.txif));                 // [R21]
	end

	// read data stands for one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (reset || !rd) begin
			rdata <= 8'h00;
		end else begin
			unique case (addr)
			`UCC_A_STATUS: rdata <= st;
			`UCC_A_CTRL1:  rdata <= {c1[7:2], rx_ninth, 1'b0};
			`UCC_A_CTRL2:  rdata <= c2;
			`UCC_A_DATA:   rdata <= rx_data;
			`UCC_A_DIVL:   rdata <= div_l;
			`UCC_A_DIVH:   rdata <= div_h;
			default:       rdata <= 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_out_float;
		!tx_on |-> serial_out_oe_n ##1 serial_out_pin;
	endproperty
	a_out_float: assert property (p_out_float) // [R1] [R12]
		else $error("output driven while transmitter off");

	property p_disable_flags;
		$fell(en) |=> st.tidle && st.txif && st.ridle && !st.rxif
			&& !st.oerr && !c2[`UCC_C2_TXEN] && !brk;
	endproperty
	a_disable_flags: assert property (p_disable_flags) // [R3]
		else $error("disable did not reset flags");

	property p_txen_empty;
		$rose(tx_on) |-> st.txif;
	endproperty
	a_txen_empty: assert property (p_txen_empty) // [R23]
		else $error("tx empty not set on enable");

	property p_break_hold;
		tx_st == UCC_TX_BREAK && brk_bits != `UCC_BREAK_BITS && tx_on
			|=> tx_st == UCC_TX_BREAK || !tx_on;
	endproperty
	a_break_hold: assert property (p_break_hold) // [R10]
		else $error("break ended early");

	property p_frame_len;
		tx_load |=> tx_left == `UCC_BASE_BITS + {3'b000, bno}
			+ {3'b000, c2[`UCC_C2_STOP]};
	endproperty
	a_frame_len: assert property (p_frame_len) // [R15] [R5]
		else $error("wrong frame length");

	property p_rx_abort;
		!rx_on |=> rx_st == UCC_RX_IDLE ##1 st.ridle || !en;
	endproperty
	a_rx_abort: assert property (p_rx_abort) // [R13]
		else $error("receiver not reset");

	property p_addr_drop;
		rx_done && !keep && !st.rxif && en |=> !st.rxif || !en;
	endproperty
	a_addr_drop: assert property (p_addr_drop) // [R17]
		else $error("data word kept under address detect");

	property p_wake_gate;
		wake_req |-> $past(src_clk_off) && $past(c2[`UCC_C2_WAKE]);
	endproperty
	a_wake_gate: assert property (p_wake_gate) // [R18]
		else $error("wake without stopped clock");

	property p_rx_irq;
		en && c2[`UCC_C2_RIE] && st.rxif |=> irq;
	endproperty
	a_rx_irq: assert property (p_rx_irq) // [R19] [R24]
		else $error("receive request missing");

	property p_idle_irq;
		irq |-> $past(c2[`UCC_C2_RIE] || (c2[`UCC_C2_TIIE] && st.tidle)
			|| (c2[`UCC_C2_TEIE] && st.txif));
	endproperty
	a_idle_irq: assert property (p_idle_irq) // [R20] [R21]
		else $error("request from disabled source");

	property p_err_clear;
		en && snap.ferr && dat_rd && !rx_store |=> !st.ferr;
	endproperty
	a_err_clear: assert property (p_err_clear) // [R22]
		else $error("error flag survived clear sequence");

endmodule

/* File: sim/ucc_remote.sv */
`timescale 1ns/1ps
// remote transceiver on the serial lines, sixteen clocks per bit
module ucc_remote (
	input  wire logic clk_sys,
	input  wire logic line_rx,
	output logic      line_tx
);
	localparam int BIT = 16;
	int cyc = 0;

	// free cycle count used to time start bits
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
	end

	// line idles high between frames
	initial begin
		line_tx = 1'b1;
	end

	// shift out start, word and stop bits lsb first, then idle high
	task automatic send(input logic [11:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			line_tx <= v[i];
			repeat (BIT) @(posedge clk_sys);
		end
		line_tx <= 1'b1;
	endtask

	// wait for a start bit, sample each bit at its middle
	task automatic catch(input int n, output logic [11:0] v, output int t0);
		int w;
		v = 12'h000;
		w = 0;
		while (line_rx !== 1'b0 && w < 4000) begin
			@(posedge clk_sys);
			w++;
		end
		t0 = cyc;
		repeat (BIT / 2) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			v[i] = line_rx;
			if (i < n - 1) begin
				repeat (BIT) @(posedge clk_sys);
			end
		end
	endtask
endmodule

/* File: sim/uart_control_config_tb.sv */
`timescale 1ns/1ps
`include "ucc_cfg.svh"
module uart_control_config_tb;
	localparam int BIT = 16;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic [2:0]  addr = 3'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        src_clk_off = 1'b0;
	logic [7:0]  rdata;
	logic        serial_out_pin;
	logic        serial_out_oe_n;
	logic        serial_in_pin;
	logic        serial_in_owned;
	logic        wake_req;
	logic        irq;
	logic        tx_line;
	logic [15:0] lfsr = 16'h3ab9;
	int          err_count = 0;
	int          n_checks = 0;
	int          wake_cnt = 0;
	int          low_run = 0;
	int          max_low = 0;
	int          hold[2] = '{2, 30};

	// 125 MHz clock
	always #4 clk_sys = ~clk_sys;

	// pull-up holds the transmit line high when not driven
	assign tx_line = serial_out_oe_n ? 1'b1 : serial_out_pin;

	ucc_top DUT (.clk_sys(clk_sys), .reset(reset), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
		.serial_in_pin(serial_in_pin), .serial_in_owned(serial_in_owned),
		.src_clk_off(src_clk_off), .wake_req(wake_req), .irq(irq));

	ucc_remote far (.clk_sys(clk_sys), .line_rx(tx_line),
		.line_tx(serial_in_pin));

	// wake pulses and the longest low stretch on the transmit line
	always @(posedge clk_sys) begin
		wake_cnt <= wake_cnt + int'(wake_req === 1'b1);
		low_run <= (tx_line === 1'b0) ? low_run + 1 : 0;
		if (low_run > max_low) begin
			max_low <= low_run;
		end
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// word bits for c = {nine bits, parity on, parity type}
	function automatic logic [8:0] word_of(input logic [8:0] d,
		input logic [3:0] c);
		logic [7:0] x;
		logic       p;
		x = c[3] ? d[7:0] : {1'b0, d[6:0]};
		p = c[1] ? ~c[0] : ^x ^ c[0];
		if (!c[2]) begin
			return c[3] ? d : {1'b0, d[7:0]};
		end
		return c[3] ? {p, d[7:0]} : {1'b0, p, d[6:0]};
	endfunction

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk_v(input string s, input logic [11:0] e, g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic chk_r(input string s, input int lo, hi, got);
		n_checks++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", s, lo, hi, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic rchk(input logic [2:0] a, input logic [7:0] m, e);
		logic [7:0] d;
		rreg(a, d);
		chk_v($sformatf("reg %0d", a), {4'h0, e & m}, {4'h0, d & m});
	endtask

	task automatic wait_txif;
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 64 && s[0] !== 1'b1; i++) begin
			rreg(`UCC_A_STATUS, s);
		end
	endtask

	// two words back to back, frames and spacing compared
	task automatic tx_frame(input logic [3:0] c, input logic [8:0] d,
		input logic st);
		logic [11:0] v1;
		logic [11:0] v2;
		int          t1;
		int          t2;
		int          n;
		n = 10 + int'(c[3]);
		fork
			begin
				far.catch(n, v1, t1);
				far.catch(n, v2, t2);
			end
			begin
				wreg(`UCC_A_DATA, d[7:0]);
				wait_txif;
				wreg(`UCC_A_DATA, ~d[7:0]);
			end
		join
		chk_v("frame", {2'b00, word_of(d, c), 1'b0} | (12'h1 << (n - 1)),
			v1);
		chk_v("next frame", {2'b00, word_of({d[8], ~d[7:0]}, c), 1'b0} |
			(12'h1 << (n - 1)), v2);
		chk_r("frame spacing", (n + st) * BIT, (n + st) * BIT + 4,
			t2 - t1);
	endtask

	// one word in from the far side, read back and flags cleared
	task automatic rx_frame(input logic [3:0] c, input logic [8:0] d,
		input logic bad);
		logic [8:0] w;
		logic       pe;
		pe = bad & c[2];
		w = word_of(d, c);
		if (pe) begin
			w[7 + c[3]] = ~w[7 + c[3]];
		end
		if (!c[3]) begin
			w[8] = 1'b1;
		end
		far.send({2'b11, w, 1'b0}, 11 + int'(c[3]));
		idle(8);
		rchk(`UCC_A_STATUS, 8'hff, {pe, 7'h0f});
		rchk(`UCC_A_DATA, 8'hff, c[2] & ~c[3] ? {1'b0, d[6:0]} :
			d[7:0]);
		rchk(`UCC_A_CTRL1, 8'h02, {6'h00, c[3] & ~c[2] & d[8], 1'b0});
		rchk(`UCC_A_STATUS, 8'hff, `UCC_STATUS_RST);
	endtask

	// watchdog against a hang
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_count++;
		report_and_stop;
	end

	initial begin
		logic [3:0] c;
		logic [8:0] d;
		logic [7:0] s;
		int         w0;
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		// reset values, unmapped place, enables refused while off
		rchk(`UCC_A_STATUS, 8'hff, `UCC_STATUS_RST);
		rchk(`UCC_A_CTRL1, 8'hfd, `UCC_CTRL1_RST);
		rchk(3'h6, 8'hff, 8'h00);
		chk_v("oe_n", 12'h1, {11'h0, serial_out_oe_n});
		wreg(`UCC_A_CTRL2, 8'hc0);
		rchk(`UCC_A_CTRL2, 8'hff, 8'h00);
		wreg(`UCC_A_DIVL, 8'h10);
		rchk(`UCC_A_DIVL, 8'hff, 8'h10);
		wreg(`UCC_A_CTRL1, 8'h80);
		wreg(`UCC_A_CTRL2, 8'hc0);
		rchk(`UCC_A_STATUS, 8'hff, `UCC_STATUS_RST);
		chk_v("pins", 12'h1, {10'h0, serial_out_oe_n, serial_in_owned});
		// every word length, parity code and stop count
		for (int i = 0; i < 10; i++) begin
			c = i < 2 ? {i[0], 3'b000} : {1'((i - 2) >> 2), 1'b1, 2'(i - 2)};
			lfsr = lfsr_next(lfsr);
			d = lfsr[8:0];
			wreg(`UCC_A_CTRL1, {1'b1, c, 2'b00, d[8]});
			wreg(`UCC_A_CTRL2, {2'b11, i[0], 5'h00});
			tx_frame(c, d, i[0]);
			rx_frame(c, d, i[1]);
		end
		// interrupt gating of transmit sources
		wreg(`UCC_A_CTRL1, 8'h80);
		for (int k = 0; k < 4; k++) begin
			wreg(`UCC_A_CTRL2, 8'hc0 | 8'(k));
			idle(2);
			chk_v("irq", {11'h0, k != 0}, {11'h0, irq});
		end
		// address detect with and without receive interrupt
		for (int k = 0; k < 3; k++) begin
			wreg(`UCC_A_CTRL2, k == 2 ? 8'hd0 : 8'hd4);
			far.send({3'b111, k != 0, 7'h35, 1'b0}, 11);
			idle(8);
			chk_v("irq", {11'h0, k == 1}, {11'h0, irq});
			rchk(`UCC_A_STATUS, 8'hff, k == 0 ? 8'h0b : 8'h0f);
			rreg(`UCC_A_DATA, s);
		end
		// wake only with source clock off and wake enabled
		for (int k = 0; k < 3; k++) begin
			wreg(`UCC_A_CTRL2, k == 1 ? 8'hc4 : 8'hcc);
			src_clk_off <= k != 0;
			w0 = wake_cnt;
			far.send(12'hffe, 11);
			idle(8);
			chk_v("wake", {11'h0, k == 2}, 12'(wake_cnt - w0));
			src_clk_off <= 1'b0;
			rreg(`UCC_A_STATUS, s);
			rreg(`UCC_A_DATA, s);
		end
		// break short and long
		wreg(`UCC_A_CTRL2, 8'hc0);
		for (int k = 0; k < 2; k++) begin
			wreg(`UCC_A_CTRL1, 8'h84);
			idle(hold[k] * BIT);
			wreg(`UCC_A_CTRL1, 8'h80);
			idle(15 * BIT);
			w0 = (hold[k] > 13 ? hold[k] : 13) * BIT;
			chk_r("break length", w0 - 4, w0 + 40, max_low);
			chk_v("line", 12'h1, {11'h0, tx_line});
		end
		// transmitter off mid-frame, then unit off mid-frame
		wreg(`UCC_A_CTRL1, 8'ha8);
		wreg(`UCC_A_CTRL2, 8'he6);
		wreg(`UCC_A_DATA, 8'h55);
		idle(40);
		wreg(`UCC_A_CTRL2, 8'h66);
		#1;
		chk_v("oe_n", 12'h1, {11'h0, serial_out_oe_n});
		rchk(`UCC_A_STATUS, 8'hff, `UCC_STATUS_RST);
		wreg(`UCC_A_CTRL2, 8'he6);
		wreg(`UCC_A_DATA, 8'h55);
		idle(40);
		wreg(`UCC_A_CTRL1, 8'h28);
		rchk(`UCC_A_CTRL1, 8'hfd, 8'h28);
		rchk(`UCC_A_CTRL2, 8'hff, 8'h26);
		rchk(`UCC_A_STATUS, 8'hff, `UCC_STATUS_RST);
		chk_v("pins", 12'h2, {10'h0, serial_out_oe_n, serial_in_owned});
		wreg(`UCC_A_CTRL1, 8'ha8);
		wreg(`UCC_A_CTRL2, 8'he6);
		rchk(`UCC_A_CTRL1, 8'hfd, 8'ha8);
		tx_frame(4'b0101, 9'h0c3, 1'b1);
		report_and_stop;
	end
endmodule
